/* verilog/slpc_map.vh */
`ifndef SLPC_MAP_VH
`define SLPC_MAP_VH

// --------------------------------------------------------------
// register indices (byte address = index * 4)
// --------------------------------------------------------------
`define SLPC_IDX_CURRENT_LOOP_GAINS 8'h8c
`define SLPC_IDX_SPEED_LOOP_GAINS_AND_LIMIT 8'h8e
`define SLPC_IDX_PROFILE_SELECT_AND_THRESHOLDS 8'h94
`define SLPC_IDX_PROFILE_DUTY_BREAKPOINTS 8'h96
`define SLPC_IDX_PROFILE_DUTY_TAIL 8'h98
`define SLPC_ADDR_W 10

// --------------------------------------------------------------
// writable bit masks and reset values
// --------------------------------------------------------------
`define SLPC_MASK_CURRENT_LOOP_GAINS 32'h00000007
`define SLPC_MASK_FULL_WORD 32'h7fffffff
`define SLPC_MASK_PROFILE_DUTY_TAIL 32'h78000000
`define SLPC_RESET_WORD 32'h00000000

// --------------------------------------------------------------
// field positions
// --------------------------------------------------------------
`define SLPC_PROP_GAIN_HI_MSB 2
`define SLPC_PROP_GAIN_HI_LSB 0
`define SLPC_PROP_GAIN_LO_MSB 30
`define SLPC_PROP_GAIN_LO_LSB 24
`define SLPC_INT_GAIN_MSB 23
`define SLPC_INT_GAIN_LSB 14
`define SLPC_MAX_SPEED_MSB 13
`define SLPC_MAX_SPEED_LSB 0
`define SLPC_PROFILE_SEL_MSB 30
`define SLPC_PROFILE_SEL_LSB 29
`define SLPC_DUTY_ON_MSB 28
`define SLPC_DUTY_ON_LSB 21
`define SLPC_DUTY_OFF_MSB 20
`define SLPC_DUTY_OFF_LSB 13
`define SLPC_DUTY_CLAMP_MSB 12
`define SLPC_DUTY_CLAMP_LSB 5
`define SLPC_DUTY_A_HI_MSB 4
`define SLPC_DUTY_A_HI_LSB 0
`define SLPC_DUTY_A_LO_MSB 30
`define SLPC_DUTY_A_LO_LSB 28
`define SLPC_DUTY_B_MSB 27
`define SLPC_DUTY_B_LSB 20
`define SLPC_DUTY_C_MSB 19
`define SLPC_DUTY_C_LSB 12
`define SLPC_DUTY_D_MSB 11
`define SLPC_DUTY_D_LSB 4
`define SLPC_DUTY_E_HI_MSB 3
`define SLPC_DUTY_E_HI_LSB 0
`define SLPC_DUTY_E_LO_MSB 30
`define SLPC_DUTY_E_LO_LSB 27

// --------------------------------------------------------------
// profile selector codes and scaling constants
// --------------------------------------------------------------
`define SLPC_PROFILE_SPEED_REF 2'h0
`define SLPC_PROFILE_LINEAR 2'h1
`define SLPC_PROFILE_STAIRCASE 2'h2
`define SLPC_PROFILE_FWD_REV 2'h3
`define SLPC_SPEED_DIVISOR 14'h0006
`define SLPC_DUTY_FULL_SCALE 15'h00ff
`define SLPC_PERCENT 8'h64

// --------------------------------------------------------------
// AXI responses
// --------------------------------------------------------------
`define SLPC_RESP_OKAY 2'h0
`define SLPC_RESP_SLVERR 2'h2

`endif

/* verilog/slpc_word.v */
`timescale 1ns/1ps
`include "slpc_map.vh"

// one 32-bit configuration word; bits outside the mask stay zero
module slpc_word #(
  parameter [31:0] WMASK = 32'h7fffffff
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // write port
  input wire wr_en,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // stored value
  output wire [31:0] q
);

  reg [31:0] word_reg;
  reg [31:0] word_next;
  integer i;

  always @* begin
    word_next = word_reg;
    if (wr_en) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (wstrb[i]) begin
          word_next[i*8 +: 8] = wdata[i*8 +: 8];
        end
      end
    end
    word_next = word_next & WMASK;
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      word_reg <= `SLPC_RESET_WORD;
    end else begin
      word_reg <= word_next;
    end
  end

  assign q = word_reg;

endmodule // slpc_word

/* verilog/slpc_regs.v */
`timescale 1ns/1ps
`include "slpc_map.vh"

// Behaviour
// R01 - speed-loop proportional gain low seven bits sit in bits 30:24 of gain word
// R02 - its top three bits sit in bits 2:0 of the preceding word
// R03 - proportional gain equals 0.01 times low byte over ten to top bits
// R04 - integral gain bits 23:14, 0.1 times low byte over ten to top bits
// R05 - maximum speed bits 13:0, electrical hertz equal field divided by six
// R06 - profile selector bits 30:29: reference, linear, staircase, forward-reverse
// R07 - turn-on duty threshold bits 28:21, percent is value over 255 times 100
// R08 - turn-off duty threshold bits 20:13, same percent scaling
// R09 - clamp duty threshold bits 12:5, same percent scaling
// R10 - breakpoint A top five bits in bits 4:0 of profile-select word
// R11 - breakpoint A low three bits in bits 30:28 of breakpoint word
// R12 - breakpoint B bits 27:20, percent scaled
// R13 - breakpoint C bits 19:12, percent scaled
// R14 - breakpoint D bits 11:4, percent scaled
// R15 - breakpoint E top four bits in bits 3:0 of breakpoint word
// R16 - breakpoint E low four bits in bits 30:27 of following word
// R17 - gain word at index 8Eh, all fields zero after reset
// R18 - bit 31 of every word reads zero and ignores writes
module slpc_regs (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // axi4-lite write address
  input wire [11:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [11:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // speed loop
  output wire [9:0] speed_loop_prop_gain,
  output wire [9:0] speed_loop_integral_gain,
  output reg [17:0] prop_gain_e5_reg,
  output reg [17:0] integral_gain_e4_reg,
  output wire [13:0] max_speed,
  output reg [11:0] max_speed_hz_reg,
  // reference profile mode, one-hot
  output reg mode_speed_ref_reg,
  output reg mode_linear_reg,
  output reg mode_staircase_reg,
  output reg mode_fwd_rev_reg,
  // duty thresholds and breakpoints, raw codes
  output wire [7:0] turn_on_duty_threshold,
  output wire [7:0] turn_off_duty_threshold,
  output wire [7:0] clamp_duty_threshold,
  output wire [7:0] duty_a,
  output wire [7:0] duty_b,
  output wire [7:0] duty_c,
  output wire [7:0] duty_d,
  output wire [7:0] duty_e,
  // duty values in whole percent
  output reg [6:0] turn_on_pct_reg,
  output reg [6:0] turn_off_pct_reg,
  output reg [6:0] clamp_pct_reg,
  output reg [6:0] duty_a_pct_reg,
  output reg [6:0] duty_b_pct_reg,
  output reg [6:0] duty_c_pct_reg,
  output reg [6:0] duty_d_pct_reg,
  output reg [6:0] duty_e_pct_reg
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // word index of a byte address; low two bits ignored
  function [7:0] word_index;
    input [11:0] addr;
    begin
      word_index = addr[9:2];
    end
  endfunction

  function mapped;
    input [7:0] idx;
    begin
      mapped = (idx == `SLPC_IDX_CURRENT_LOOP_GAINS) ||
               (idx == `SLPC_IDX_SPEED_LOOP_GAINS_AND_LIMIT) ||
               (idx == `SLPC_IDX_PROFILE_SELECT_AND_THRESHOLDS) ||
               (idx == `SLPC_IDX_PROFILE_DUTY_BREAKPOINTS) ||
               (idx == `SLPC_IDX_PROFILE_DUTY_TAIL);
    end
  endfunction

  // code/255*100, truncated to whole percent
  function [6:0] duty_pct;
    input [7:0] code;
    reg [14:0] prod;
    reg [14:0] quot;
    begin
      prod = {7'h00, code} * {7'h00, `SLPC_PERCENT};
      quot = prod / `SLPC_DUTY_FULL_SCALE;
      duty_pct = quot[6:0];
    end
  endfunction

  // mantissa * 10^(3-exp): gain in steps of 1e-5 (prop) or 1e-4 (int)
  function [17:0] gain_scale;
    input [9:0] field;
    reg [9:0] mult;
    begin
      case (field[9:8])
        2'h0: mult = 10'h3e8;
        2'h1: mult = 10'h064;
        2'h2: mult = 10'h00a;
        default: mult = 10'h001;
      endcase
      gain_scale = {10'h000, field[7:0]} * {8'h00, mult};
    end
  endfunction

  // ------------------------------------------------------------
  // write channel
  // ------------------------------------------------------------
  reg aw_full_reg;
  reg w_full_reg;
  reg [11:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;

  // address and data may arrive in either order; each is held
  // until both are present and the previous response has gone
  wire wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
  wire [7:0] wr_idx = word_index(awaddr_reg);

  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `SLPC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_full_reg <= 1'b0;
      end
      if (s_axi_wvalid && !w_full_reg) begin
        w_full_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_full_reg <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(wr_idx) ? `SLPC_RESP_OKAY : `SLPC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // register words
  // ------------------------------------------------------------
  wire [31:0] cur_gains_q;
  wire [31:0] spd_gains_q;
  wire [31:0] prof_sel_q;
  wire [31:0] prof_bp_q;
  wire [31:0] prof_tail_q;

  // R02 only the proportional-gain top bits are kept here
  slpc_word #(.WMASK(`SLPC_MASK_CURRENT_LOOP_GAINS)) u_cur_gains (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(wr_fire && (wr_idx == `SLPC_IDX_CURRENT_LOOP_GAINS)),
    .wdata(wdata_reg),
    .wstrb(wstrb_reg),
    .q(cur_gains_q)
  );

  // R17 gain word decode, zero at reset
  // R18 bit 31 masked off in every word
  slpc_word #(.WMASK(`SLPC_MASK_FULL_WORD)) u_spd_gains (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(wr_fire && (wr_idx == `SLPC_IDX_SPEED_LOOP_GAINS_AND_LIMIT)),
    .wdata(wdata_reg),
    .wstrb(wstrb_reg),
    .q(spd_gains_q)
  );

  slpc_word #(.WMASK(`SLPC_MASK_FULL_WORD)) u_prof_sel (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(wr_fire && (wr_idx == `SLPC_IDX_PROFILE_SELECT_AND_THRESHOLDS)),
    .wdata(wdata_reg),
    .wstrb(wstrb_reg),
    .q(prof_sel_q)
  );

  slpc_word #(.WMASK(`SLPC_MASK_FULL_WORD)) u_prof_bp (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(wr_fire && (wr_idx == `SLPC_IDX_PROFILE_DUTY_BREAKPOINTS)),
    .wdata(wdata_reg),
    .wstrb(wstrb_reg),
    .q(prof_bp_q)
  );

  // R16 only the breakpoint-E low bits are kept here
  slpc_word #(.WMASK(`SLPC_MASK_PROFILE_DUTY_TAIL)) u_prof_tail (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(wr_fire && (wr_idx == `SLPC_IDX_PROFILE_DUTY_TAIL)),
    .wdata(wdata_reg),
    .wstrb(wstrb_reg),
    .q(prof_tail_q)
  );

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;
  reg [31:0] rd_word;
  wire [7:0] rd_idx = word_index(s_axi_araddr);

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // unmapped reads return zero with an error response
  always @* begin
    case (rd_idx)
      `SLPC_IDX_CURRENT_LOOP_GAINS: rd_word = cur_gains_q;
      `SLPC_IDX_SPEED_LOOP_GAINS_AND_LIMIT: rd_word = spd_gains_q;
      `SLPC_IDX_PROFILE_SELECT_AND_THRESHOLDS: rd_word = prof_sel_q;
      `SLPC_IDX_PROFILE_DUTY_BREAKPOINTS: rd_word = prof_bp_q;
      `SLPC_IDX_PROFILE_DUTY_TAIL: rd_word = prof_tail_q;
      default: rd_word = 32'h00000000;
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `SLPC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && !rvalid_reg) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= mapped(rd_idx) ? `SLPC_RESP_OKAY : `SLPC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // field assembly
  // ------------------------------------------------------------
  // R01 low seven bits from the gain word
  // R02 top three bits from the word below
  assign speed_loop_prop_gain = {
    cur_gains_q[`SLPC_PROP_GAIN_HI_MSB:`SLPC_PROP_GAIN_HI_LSB],
    spd_gains_q[`SLPC_PROP_GAIN_LO_MSB:`SLPC_PROP_GAIN_LO_LSB]};
  // R04 integral gain field
  assign speed_loop_integral_gain =
    spd_gains_q[`SLPC_INT_GAIN_MSB:`SLPC_INT_GAIN_LSB];
  // R05 maximum speed field
  assign max_speed = spd_gains_q[`SLPC_MAX_SPEED_MSB:`SLPC_MAX_SPEED_LSB];
  // R07 turn-on threshold field
  assign turn_on_duty_threshold = prof_sel_q[`SLPC_DUTY_ON_MSB:`SLPC_DUTY_ON_LSB];
  // R08 turn-off threshold field
  assign turn_off_duty_threshold = prof_sel_q[`SLPC_DUTY_OFF_MSB:`SLPC_DUTY_OFF_LSB];
  // R09 clamp threshold field
  assign clamp_duty_threshold = prof_sel_q[`SLPC_DUTY_CLAMP_MSB:`SLPC_DUTY_CLAMP_LSB];
  // R10 R11 breakpoint A joined across two words
  assign duty_a = {prof_sel_q[`SLPC_DUTY_A_HI_MSB:`SLPC_DUTY_A_HI_LSB],
                   prof_bp_q[`SLPC_DUTY_A_LO_MSB:`SLPC_DUTY_A_LO_LSB]};
  // R12 breakpoint B
  assign duty_b = prof_bp_q[`SLPC_DUTY_B_MSB:`SLPC_DUTY_B_LSB];
  // R13 breakpoint C
  assign duty_c = prof_bp_q[`SLPC_DUTY_C_MSB:`SLPC_DUTY_C_LSB];
  // R14 breakpoint D
  assign duty_d = prof_bp_q[`SLPC_DUTY_D_MSB:`SLPC_DUTY_D_LSB];
  // R15 R16 breakpoint E joined across two words
  assign duty_e = {prof_bp_q[`SLPC_DUTY_E_HI_MSB:`SLPC_DUTY_E_HI_LSB],
                   prof_tail_q[`SLPC_DUTY_E_LO_MSB:`SLPC_DUTY_E_LO_LSB]};

  wire [1:0] profile_sel = prof_sel_q[`SLPC_PROFILE_SEL_MSB:`SLPC_PROFILE_SEL_LSB];
  wire [13:0] speed_div = max_speed / `SLPC_SPEED_DIVISOR;

  // ------------------------------------------------------------
  // scaled values, one cycle behind the stored words
  // ------------------------------------------------------------
  // registered so the divides stay off the bus timing path
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prop_gain_e5_reg <= 18'h00000;
      integral_gain_e4_reg <= 18'h00000;
      max_speed_hz_reg <= 12'h000;
      mode_speed_ref_reg <= 1'b1;
      mode_linear_reg <= 1'b0;
      mode_staircase_reg <= 1'b0;
      mode_fwd_rev_reg <= 1'b0;
      turn_on_pct_reg <= 7'h00;
      turn_off_pct_reg <= 7'h00;
      clamp_pct_reg <= 7'h00;
      duty_a_pct_reg <= 7'h00;
      duty_b_pct_reg <= 7'h00;
      duty_c_pct_reg <= 7'h00;
      duty_d_pct_reg <= 7'h00;
      duty_e_pct_reg <= 7'h00;
    end else begin
      // R03 proportional gain scaling
      prop_gain_e5_reg <= gain_scale(speed_loop_prop_gain);
      // R04 integral gain scaling
      integral_gain_e4_reg <= gain_scale(speed_loop_integral_gain);
      // R05 field over six
      max_speed_hz_reg <= speed_div[11:0];
      // R06 selector decode
      mode_speed_ref_reg <= (profile_sel == `SLPC_PROFILE_SPEED_REF);
      mode_linear_reg <= (profile_sel == `SLPC_PROFILE_LINEAR);
      mode_staircase_reg <= (profile_sel == `SLPC_PROFILE_STAIRCASE);
      mode_fwd_rev_reg <= (profile_sel == `SLPC_PROFILE_FWD_REV);
      // R07 R08 R09 threshold percent
      turn_on_pct_reg <= duty_pct(turn_on_duty_threshold);
      turn_off_pct_reg <= duty_pct(turn_off_duty_threshold);
      clamp_pct_reg <= duty_pct(clamp_duty_threshold);
      // R11 R12 R13 R14 R16 breakpoint percent
      duty_a_pct_reg <= duty_pct(duty_a);
      duty_b_pct_reg <= duty_pct(duty_b);
      duty_c_pct_reg <= duty_pct(duty_c);
      duty_d_pct_reg <= duty_pct(duty_d);
      duty_e_pct_reg <= duty_pct(duty_e);
    end
  end

endmodule // slpc_regs

/* bench/slpc_regs_asserts.sv */
`timescale 1ns/1ps

module slpc_regs_asserts (
  // clock and reset
  input logic clk,
  input logic reset_n,
  // register bus handshakes
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  // decoded outputs
  input logic [9:0] speed_loop_integral_gain,
  input logic [17:0] integral_gain_e4_reg,
  input logic [13:0] max_speed,
  input logic [11:0] max_speed_hz_reg,
  input logic mode_speed_ref_reg,
  input logic mode_linear_reg,
  input logic mode_staircase_reg,
  input logic mode_fwd_rev_reg,
  input logic [7:0] turn_on_duty_threshold,
  input logic [6:0] turn_on_pct_reg,
  input logic [7:0] duty_e,
  input logic [6:0] duty_e_pct_reg
);
  // low byte times ten to the power of three minus the top two bits
  function automatic [17:0] gain_scaled(input [9:0] f);
    case (f[9:8])
      2'h0: gain_scaled = f[7:0] * 18'h003e8;
      2'h1: gain_scaled = f[7:0] * 18'h00064;
      2'h2: gain_scaled = f[7:0] * 18'h0000a;
      default: gain_scaled = {10'h000, f[7:0]};
    endcase
  endfunction

  function automatic [6:0] pct(input [7:0] c);
    pct = 7'(({8'h00, c} * 16'h0064) / 16'h00ff);
  endfunction

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  chk_resp_held: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_data_held: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_reserved_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31] == 1'b0)
    else $error("reserved bit reads one");
  chk_mode_onehot: assert property (
    $onehot({mode_fwd_rev_reg, mode_staircase_reg, mode_linear_reg, mode_speed_ref_reg}))
    else $error("profile mode not one-hot");
  chk_speed_hz: assert property (
    max_speed_hz_reg == $past(max_speed) / 14'h0006)
    else $error("speed in hertz wrong");
  chk_int_gain: assert property (
    integral_gain_e4_reg == gain_scaled($past(speed_loop_integral_gain)))
    else $error("integral gain scaling wrong");
  chk_turn_on_pct: assert property (
    turn_on_pct_reg == pct($past(turn_on_duty_threshold)))
    else $error("turn-on percent wrong");
  chk_duty_e_pct: assert property (
    duty_e_pct_reg == pct($past(duty_e)))
    else $error("breakpoint E percent wrong");
endmodule // slpc_regs_asserts

bind slpc_regs slpc_regs_asserts u_slpc_chk (
  .clk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .speed_loop_integral_gain,
  .integral_gain_e4_reg, .max_speed, .max_speed_hz_reg, .mode_speed_ref_reg,
  .mode_linear_reg, .mode_staircase_reg, .mode_fwd_rev_reg, .turn_on_duty_threshold,
  .turn_on_pct_reg, .duty_e, .duty_e_pct_reg
);

/* bench/slpc_regs_tb_top.sv */
`timescale 1ns/1ps
`include "slpc_map.vh"

module slpc_regs_tb_top;
  localparam [7:0] idx_lo = `SLPC_IDX_CURRENT_LOOP_GAINS;
  localparam [7:0] idx_gain = `SLPC_IDX_SPEED_LOOP_GAINS_AND_LIMIT;
  localparam [7:0] idx_sel = `SLPC_IDX_PROFILE_SELECT_AND_THRESHOLDS;
  localparam [7:0] idx_bp = `SLPC_IDX_PROFILE_DUTY_BREAKPOINTS;
  localparam [7:0] idx_tail = `SLPC_IDX_PROFILE_DUTY_TAIL;
  localparam [1:0] ok = `SLPC_RESP_OKAY;
  localparam [1:0] err = `SLPC_RESP_SLVERR;

  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [9:0] speed_loop_prop_gain, speed_loop_integral_gain;
  wire [17:0] prop_gain_e5_reg, integral_gain_e4_reg;
  wire [13:0] max_speed;
  wire [11:0] max_speed_hz_reg;
  wire mode_speed_ref_reg, mode_linear_reg, mode_staircase_reg, mode_fwd_rev_reg;
  wire [7:0] turn_on_duty_threshold, turn_off_duty_threshold, clamp_duty_threshold;
  wire [7:0] duty_a, duty_b, duty_c, duty_d, duty_e;
  wire [6:0] turn_on_pct_reg, turn_off_pct_reg, clamp_pct_reg, duty_a_pct_reg;
  wire [6:0] duty_b_pct_reg, duty_c_pct_reg, duty_d_pct_reg, duty_e_pct_reg;
  int failures = 0;
  int num_checks = 0;

  always #50 clk = ~clk;

  slpc_regs dut (
    .clk, .reset_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .speed_loop_prop_gain, .speed_loop_integral_gain, .prop_gain_e5_reg,
    .integral_gain_e4_reg, .max_speed, .max_speed_hz_reg, .mode_speed_ref_reg,
    .mode_linear_reg, .mode_staircase_reg, .mode_fwd_rev_reg, .turn_on_duty_threshold,
    .turn_off_duty_threshold, .clamp_duty_threshold, .duty_a, .duty_b, .duty_c,
    .duty_d, .duty_e, .turn_on_pct_reg, .turn_off_pct_reg, .clamp_pct_reg,
    .duty_a_pct_reg, .duty_b_pct_reg, .duty_c_pct_reg, .duty_d_pct_reg, .duty_e_pct_reg
  );

  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic check(input [31:0] got, input [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // ready is offered up front and held until the answer is seen; one idle edge
  // follows so the next call never re-raises a strobe in the same time step
  task automatic axi_write(input [7:0] idx, input [31:0] data, input [3:0] strb,
                           input [1:0] resp);
    int n;
    logic got_valid;
    logic [1:0] got_resp;
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= data;
    s_axi_wstrb <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    got_valid = s_axi_bvalid;
    got_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
    check({31'h0, got_valid}, 32'h1);
    check({30'h0, got_resp}, {30'h0, resp});
  endtask

  task automatic axi_read(input [7:0] idx, input [31:0] exp, input [1:0] resp);
    int n;
    logic got_valid;
    logic [31:0] got_data;
    logic [1:0] got_resp;
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    got_valid = s_axi_rvalid;
    got_data = s_axi_rdata;
    got_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
    check({31'h0, got_valid}, 32'h1);
    check(got_data, exp);
    check({30'h0, got_resp}, {30'h0, resp});
  endtask

  task automatic apply_reset;
    reset_n <= 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_reset;
    axi_read(idx_gain, 32'h0, ok);
    axi_read(idx_sel, 32'h0, ok);
    axi_read(idx_bp, 32'h0, ok);
    check({31'h0, mode_speed_ref_reg}, 32'h1);
    $display("test_reset done");
  endtask

  task automatic test_gain;
    axi_write(idx_lo, 32'hfffffffd, 4'hf, ok);
    axi_read(idx_lo, 32'h00000005, ok);
    axi_write(idx_gain, 32'h95722710, 4'hf, ok);
    axi_read(idx_gain, 32'h15722710, ok);
    axi_write(idx_gain, 32'h00000000, 4'h1, ok);
    axi_read(idx_gain, 32'h15722700, ok);
    check({22'h0, speed_loop_prop_gain}, 32'h295);
    check({14'h0, prop_gain_e5_reg}, 149 * 10);
    check({14'h0, integral_gain_e4_reg}, 200 * 100);
    check({20'h0, max_speed_hz_reg}, 32'h2700 / 6);
    axi_write(idx_lo, 32'h00000000, 4'hf, ok);
    axi_write(idx_gain, 32'h7fffc000, 4'hf, ok);
    check({14'h0, prop_gain_e5_reg}, 127 * 1000);
    check({14'h0, integral_gain_e4_reg}, 255);
    $display("test_gain done");
  endtask

  task automatic test_profile;
    logic [31:0] w;
    for (int s = 0; s < 4; s++) begin
      w = {1'b0, 2'(s), 8'hff, 8'h80, 8'h01, 5'h1a};
      axi_write(idx_sel, w, 4'hf, ok);
      axi_read(idx_sel, w, ok);
      check({28'h0, mode_fwd_rev_reg, mode_staircase_reg, mode_linear_reg,
             mode_speed_ref_reg}, 32'h1 << s);
    end
    check({25'h0, turn_on_pct_reg}, 100);
    check({25'h0, turn_off_pct_reg}, 128 * 100 / 255);
    check({17'h0, clamp_duty_threshold, clamp_pct_reg}, 32'h80);
    $display("test_profile done");
  endtask

  task automatic test_breakpoints;
    axi_write(idx_tail, 32'hffffffff, 4'hf, ok);
    axi_read(idx_tail, 32'h78000000, ok);
    axi_write(idx_tail, 32'h28000000, 4'hf, ok);
    axi_write(idx_bp, 32'hb33cc00a, 4'hf, ok);
    axi_read(idx_bp, 32'h333cc00a, ok);
    check({duty_a, duty_b, duty_c, duty_d}, 32'hd333cc00);
    check({4'h0, duty_a_pct_reg, duty_b_pct_reg, duty_c_pct_reg, duty_d_pct_reg},
          {4'h0, 7'(211 * 100 / 255), 7'(51 * 100 / 255), 7'(204 * 100 / 255),
           7'h00});
    check({17'h0, duty_e, duty_e_pct_reg}, {17'h0, 8'ha5, 7'(165 * 100 / 255)});
    $display("test_breakpoints done");
  endtask

  task automatic test_unmapped;
    axi_write(8'h90, 32'h12345678, 4'hf, err);
    axi_read(8'h90, 32'h0, err);
    axi_read(idx_gain, 32'h7fffc000, ok);
    $display("test_unmapped done");
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    apply_reset;
    test_reset;
    test_gain;
    test_profile;
    test_breakpoints;
    test_unmapped;
    apply_reset;
    test_reset;
    finish_test;
  end

  // the sequence needs well under a thousand cycles
  initial begin
    #(100 * 3000);
    failures++;
    finish_test;
  end
endmodule // slpc_regs_tb_top
